/* File: inc/awsc_pkg.sv */
package awsc_pkg;
    // Register addresses
    localparam logic [7:0] AWSC_ADDR_INACT   = 8'h29;
    localparam logic [7:0] AWSC_ADDR_SYS1    = 8'h2A;
    localparam logic [7:0] AWSC_ADDR_SYS2    = 8'h2B;
    localparam logic [7:0] AWSC_ADDR_WAKESEL = 8'h2C;
    localparam logic [7:0] AWSC_ADDR_INTEN   = 8'h2D;
    localparam logic [7:0] AWSC_ADDR_STATUS  = 8'h0B;
    // Field positions
    localparam int AWSC_SLP_RATE_LSB = 6;
    localparam int AWSC_ACT_RATE_LSB = 3;
    localparam int AWSC_ACTIVE_BIT   = 0;
    localparam int AWSC_AUTOSLEEP_ENABLE_BIT     = 2;
    localparam int AWSC_WAKE_LSB     = 3;  // Wake selects bits 6:3
    localparam int AWSC_INT_SLP_BIT  = 7;
    localparam int AWSC_INT_EV_LSB   = 2;  // Event enables bits 5:2
    localparam logic [7:0] AWSC_REG_RESET = 8'h00;
    // Rate codes
    localparam logic [2:0] AWSC_RATE_1HZ56 = 3'h7;
    // Step lengths in microseconds and the default clock period in ns
    localparam int AWSC_STEP_US      = 320000;
    localparam int AWSC_STEP_SLOW_US = 640000;
    localparam int AWSC_CLK_NS       = 25;
    // Sample periods in ns for the eight active codes
    localparam int AWSC_ODR_PERIOD_NS [8] = '{1250000, 2500000, 5000000, 10000000,
                                             20000000, 80000000, 160000000, 640000000};
    // Sleep codes map onto active codes 50, 12.5, 6.25, 1.56 Hz
    localparam logic [2:0] AWSC_SLP_MAP [4] = '{3'h4, 3'h5, 3'h6, 3'h7};
    typedef enum logic [1:0] {
        AWSC_STANDBY = 2'b00,
        AWSC_WAKE    = 2'b01,
        AWSC_SLEEP   = 2'b10
    } awsc_mode_e;
endpackage

/* File: rtl/awsc_core.sv */
`timescale 1ns/1ps
module awsc_core
    import awsc_pkg::*;
#(
    parameter int CLK_NS = AWSC_CLK_NS
) (
    input  wire logic       clock_in,
    input  wire logic       srst_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_write_in,
    output logic [7:0]      reg_rdata_out,
    input  wire logic       transient_event_in,
    input  wire logic       orientation_event_in,
    input  wire logic       tap_event_in,
    input  wire logic       freefall_motion_event_in,
    input  wire logic       sample_ready_event_in,
    output logic            sample_tick_out,
    output logic [2:0]      output_sample_rate_out,
    output logic            sleeping_out,
    output logic            sleep_transition_event_out
);
    typedef struct packed {
        logic [7:0]  inactivity_duration;
        logic [7:0]  sys1;
        logic [7:0]  system_control_two;
        logic [7:0]  wake_source_select;
        logic [7:0]  interrupt_enable_reg;
        awsc_mode_e  mode;
        logic [31:0] div;        // Clock cycles toward next sample tick
        logic [9:0]  tick_cnt;   // Sample ticks toward next inactivity count
        logic [7:0]  inact_cnt;  // Inactivity counts elapsed
        logic        tick;
        logic        slp_irq;
        logic [7:0]  rdata;
    } awsc_state_s;

    awsc_state_s s_q;
    awsc_state_s s_d;
    logic [3:0]  ev_vec;

    // Cycles per sample at a given rate code
    function automatic logic [31:0] period_cycles(input logic [2:0] code);
        period_cycles = 32'(AWSC_ODR_PERIOD_NS[code] / CLK_NS);
    endfunction

    // Sample ticks per inactivity step at the active rate
    function automatic logic [9:0] ticks_per_step(input logic [2:0] code);
        if (code == AWSC_RATE_1HZ56) begin
            ticks_per_step = 10'(AWSC_STEP_SLOW_US * 1000 / AWSC_ODR_PERIOD_NS[code]);
        end else begin
            ticks_per_step = 10'(AWSC_STEP_US * 1000 / AWSC_ODR_PERIOD_NS[code]);
        end
    endfunction

    assign ev_vec = {transient_event_in, orientation_event_in, tap_event_in, freefall_motion_event_in};

    always_comb begin
        logic [2:0] act_code;
        logic [2:0] cur_code;
        logic       any_ev;
        logic       wake_ev;
        logic       autosleep_enable;
        act_code = 3'h0;
        cur_code = 3'h0;
        any_ev   = 1'b0;
        wake_ev  = 1'b0;
        autosleep_enable = 1'b0;
        s_d = s_q;
        s_d.tick    = 1'b0;
        s_d.slp_irq = 1'b0;
        act_code = s_q.sys1[AWSC_ACT_RATE_LSB +: 3];
        autosleep_enable = s_q.system_control_two[AWSC_AUTOSLEEP_ENABLE_BIT];
        // Detector events only; sample-ready is deliberately ignored here
        any_ev  = |(ev_vec & s_q.interrupt_enable_reg[AWSC_INT_EV_LSB +: 4]);
        wake_ev = |(ev_vec & s_q.interrupt_enable_reg[AWSC_INT_EV_LSB +: 4]
                    & s_q.wake_source_select[AWSC_WAKE_LSB +: 4]);
        // Sleep overrides the active rate for the whole sample path
        cur_code = (s_q.mode == AWSC_SLEEP)
                 ? AWSC_SLP_MAP[s_q.sys1[AWSC_SLP_RATE_LSB +: 2]] : act_code;

        // Sample-rate divider, cleared to zero while in standby
        if (s_q.mode == AWSC_STANDBY) begin
            s_d.div = 32'h0;
        end else if (s_q.div + 32'h1 >= period_cycles(cur_code)) begin
            s_d.div  = 32'h0;
            s_d.tick = 1'b1;
        end else begin
            s_d.div = s_q.div + 32'h1;
        end

        unique case (s_q.mode)
            AWSC_STANDBY: begin
                s_d.tick_cnt  = 10'h0;
                s_d.inact_cnt = 8'h0;
                if (s_q.sys1[AWSC_ACTIVE_BIT]) s_d.mode = AWSC_WAKE;
            end
            AWSC_WAKE: begin
                if (!s_q.sys1[AWSC_ACTIVE_BIT]) begin
                    s_d.mode = AWSC_STANDBY;
                end else if (any_ev || !autosleep_enable) begin
                    // Divider restarts too, so a full step of quiet is needed unless inactivity_duration is zero
                    s_d.tick_cnt  = 10'h0;
                    s_d.inact_cnt = 8'h0;
                    s_d.div       = 32'h0;
                end else if (s_q.inact_cnt >= s_q.inactivity_duration) begin
                    s_d.mode      = AWSC_SLEEP;
                    s_d.tick_cnt  = 10'h0;
                    s_d.inact_cnt = 8'h0;
                    s_d.slp_irq   = s_q.interrupt_enable_reg[AWSC_INT_SLP_BIT];
                end else if (s_q.tick) begin
                    if (s_q.tick_cnt + 10'h1 >= ticks_per_step(act_code)) begin
                        s_d.tick_cnt  = 10'h0;
                        s_d.inact_cnt = s_q.inact_cnt + 8'h1;
                    end else begin
                        s_d.tick_cnt = s_q.tick_cnt + 10'h1;
                    end
                end
            end
            AWSC_SLEEP: begin
                if (!s_q.sys1[AWSC_ACTIVE_BIT]) begin
                    s_d.mode = AWSC_STANDBY;
                end else if (wake_ev || !autosleep_enable) begin
                    s_d.mode      = AWSC_WAKE;
                    s_d.tick_cnt  = 10'h0;
                    s_d.inact_cnt = 8'h0;
                    s_d.div       = 32'h0;
                    s_d.slp_irq   = s_q.interrupt_enable_reg[AWSC_INT_SLP_BIT];
                end
            end
            default: s_d.mode = AWSC_STANDBY;
        endcase

        // Register writes; the mode field stays visible to readback
        if (reg_write_in) begin
            unique case (reg_addr_in)
                AWSC_ADDR_INACT:   s_d.inactivity_duration  = reg_wdata_in;
                AWSC_ADDR_SYS1:    s_d.sys1                 = reg_wdata_in;
                AWSC_ADDR_SYS2:    s_d.system_control_two   = reg_wdata_in;
                AWSC_ADDR_WAKESEL: s_d.wake_source_select   = reg_wdata_in;
                AWSC_ADDR_INTEN:   s_d.interrupt_enable_reg = reg_wdata_in;
                default: ;
            endcase
        end
        unique case (reg_addr_in)
            AWSC_ADDR_INACT:   s_d.rdata = s_q.inactivity_duration;
            AWSC_ADDR_SYS1:    s_d.rdata = s_q.sys1;
            AWSC_ADDR_SYS2:    s_d.rdata = s_q.system_control_two;
            AWSC_ADDR_WAKESEL: s_d.rdata = s_q.wake_source_select;
            AWSC_ADDR_INTEN:   s_d.rdata = s_q.interrupt_enable_reg;
            AWSC_ADDR_STATUS:  s_d.rdata = {6'h00, s_q.mode};
            default:           s_d.rdata = 8'h00;
        endcase

        if (srst_in) begin
            s_d = '0;
            s_d.inactivity_duration = AWSC_REG_RESET;
            s_d.mode = AWSC_STANDBY;
        end
    end

    // Single state register for the whole block
    always_ff @(posedge clock_in) begin
        s_q <= s_d;
    end

    assign reg_rdata_out              = s_q.rdata;
    assign sample_tick_out            = s_q.tick;
    assign output_sample_rate_out     = (s_q.mode == AWSC_SLEEP)
                                      ? AWSC_SLP_MAP[s_q.sys1[AWSC_SLP_RATE_LSB +: 2]]
                                      : s_q.sys1[AWSC_ACT_RATE_LSB +: 3];
    assign sleeping_out               = (s_q.mode == AWSC_SLEEP);
    assign sleep_transition_event_out = s_q.slp_irq;
endmodule // awsc_core

/* File: testbench/awsc_core_monitor.sv */
`timescale 1ns/1ps
module awsc_core_monitor
    import awsc_pkg::*;
(
    input wire logic       clock_in,
    input wire logic       srst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic       reg_write_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic       transient_event_in,
    input wire logic       orientation_event_in,
    input wire logic       tap_event_in,
    input wire logic       freefall_motion_event_in,
    input wire logic [2:0] output_sample_rate_out,
    input wire logic       sleeping_out,
    input wire logic       sleep_transition_event_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (srst_in);
    // No detector event this cycle
    wire logic quiet = !(transient_event_in | orientation_event_in | tap_event_in | freefall_motion_event_in);
    pulse_width_a: assert property (sleep_transition_event_out |=> !sleep_transition_event_out) else $error("pulse too long");
    pulse_cause_a: assert property (sleep_transition_event_out |-> sleeping_out != $past(sleeping_out)) else $error("pulse without change");
    sleep_rate_a: assert property (sleeping_out && $past(sleeping_out) |-> output_sample_rate_out[2]) else $error("bad sleep rate");
    reset_clear_a: assert property ($fell(srst_in) |-> !sleeping_out && reg_rdata_out == 8'h00) else $error("reset left state");
    no_wake_a: assert property (sleeping_out && quiet && !reg_write_in && !$past(reg_write_in) |=> sleeping_out) else $error("woke without event");
    sleep_entry_a: assert property ($rose(sleeping_out) |-> $past(quiet)) else $error("slept despite event");
    rate_hold_a: assert property (sleeping_out && $past(sleeping_out) && !$past(reg_write_in) |-> $stable(output_sample_rate_out)) else $error("rate moved in sleep");
    unmapped_read_a: assert property (reg_addr_in > AWSC_ADDR_INTEN |=> reg_rdata_out == 8'h00) else $error("unmapped read nonzero");
    status_sleep_a: assert property (reg_addr_in == AWSC_ADDR_STATUS && sleeping_out |=> reg_rdata_out == 8'h02) else $error("status not sleep");
    cover property ($rose(sleeping_out));
    cover property ($fell(sleeping_out));
    cover property (sleep_transition_event_out);
endmodule // awsc_core_monitor

/* File: testbench/test_auto_wake_sleep_control.sv */
`timescale 1ns/1ps
module test_auto_wake_sleep_control
    import awsc_pkg::*;
;
    logic       clock_in = 0, srst_in = 1, reg_write_in = 0, tick, sleeping_out, pulse;
    logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out;
    logic [4:0] ev = 5'h00;
    logic [2:0] rate;
    logic [7:0] regs [6] = '{AWSC_ADDR_INACT, AWSC_ADDR_SYS1, AWSC_ADDR_SYS2, AWSC_ADDR_WAKESEL, AWSC_ADDR_INTEN, 8'h30};
    int         err_total = 0, samples_checked = 0, cyc = 0, pulses = 0, p0, st;
    // One cycle is 1.25 ms of device time, so one inactivity step is 256 cycles, 512 at the 1.56 Hz active code
    awsc_core #(.CLK_NS(1250000)) i_awsc_core (.clock_in(clock_in), .srst_in(srst_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_rdata_out(reg_rdata_out),
        .transient_event_in(ev[3]), .orientation_event_in(ev[2]), .tap_event_in(ev[1]),
        .freefall_motion_event_in(ev[0]), .sample_ready_event_in(ev[4]), .sample_tick_out(tick),
        .output_sample_rate_out(rate), .sleeping_out(sleeping_out), .sleep_transition_event_out(pulse));
    always #12.5 clock_in = ~clock_in;
    // Pulse counter and hang guard
    always @(posedge clock_in) begin
        cyc <= cyc + 1;
        if (pulse === 1'b1) pulses <= pulses + 1;
        if (cyc == 30000) begin
            err_total++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Strobe held for exactly one rising edge, then a gap cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_write_in = 1'b1;
        @(negedge clock_in);
        reg_write_in = 1'b0;
        @(negedge clock_in);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_addr_in = a;
        @(negedge clock_in);
        chk("register", reg_rdata_out, exp);
    endtask
    task automatic fire(input int k);
        ev[k] = 1'b1;
        @(negedge clock_in);
        ev[k] = 1'b0;
        @(negedge clock_in);
    endtask
    // Main sequence, inputs move on falling edges
    initial begin
        repeat (20) @(negedge clock_in);
        srst_in = 1'b0;
        foreach (regs[i]) rd(regs[i], 8'h00);
        wr(AWSC_ADDR_INACT, 8'hA5);
        rd(AWSC_ADDR_INACT, 8'hA5);
        wr(8'h30, 8'hFF);
        rd(8'h30, 8'h00);
        wr(AWSC_ADDR_INACT, 8'h01);
        wr(AWSC_ADDR_SYS1, 8'h01);
        repeat (600) @(negedge clock_in);
        rd(AWSC_ADDR_STATUS, 8'h01);
        chk("sample tick", tick, 8'h01);
        $display("register and standby test done");
        wr(AWSC_ADDR_INTEN, 8'h80);
        for (int i = 0; i < 5; i++) begin
            st = (i == 4) ? 512 : 256;
            wr(AWSC_ADDR_SYS2, 8'h00);
            wr(AWSC_ADDR_SYS1, 8'h00);
            wr(AWSC_ADDR_SYS2, 8'h04);
            p0 = pulses;
            wr(AWSC_ADDR_SYS1, {i[1:0], (i == 4) ? 3'h7 : i[2:0], 3'h1});
            repeat (st - 30) @(negedge clock_in);
            chk("early sleep", sleeping_out, 8'h00);
            repeat (60) @(negedge clock_in);
            chk("sleep flag", sleeping_out, 8'h01);
            chk("sleep rate", rate, 8'(4 + i % 4));
            chk("pulses", 8'(pulses - p0), 8'h01);
            rd(AWSC_ADDR_STATUS, 8'h02);
        end
        $display("sleep entry test done");
        wr(AWSC_ADDR_WAKESEL, 8'h40);
        fire(3);
        chk("no enable wake", sleeping_out, 8'h01);
        wr(AWSC_ADDR_INTEN, 8'hBC);
        wr(AWSC_ADDR_WAKESEL, 8'h00);
        fire(3);
        fire(4);
        chk("unselected wake", sleeping_out, 8'h01);
        for (int k = 0; k < 4; k++) begin
            wr(AWSC_ADDR_WAKESEL, 8'h08 << k);
            fire(k);
            chk("event wake", sleeping_out, 8'h00);
            chk("active rate", rate, 8'h07);
            repeat (400) @(negedge clock_in);
            fire(k);
            repeat (450) @(negedge clock_in);
            chk("timer restart", sleeping_out, 8'h00);
            repeat (100) @(negedge clock_in);
            chk("sleep again", sleeping_out, 8'h01);
        end
        $display("wake event test done");
        close_out();
    end
endmodule // test_auto_wake_sleep_control
bind awsc_core awsc_core_monitor i_awsc_core_monitor (.clock_in(clock_in), .srst_in(srst_in),
    .reg_addr_in(reg_addr_in), .reg_write_in(reg_write_in), .reg_rdata_out(reg_rdata_out),
    .transient_event_in(transient_event_in), .orientation_event_in(orientation_event_in),
    .tap_event_in(tap_event_in), .freefall_motion_event_in(freefall_motion_event_in),
    .output_sample_rate_out(output_sample_rate_out), .sleeping_out(sleeping_out),
    .sleep_transition_event_out(sleep_transition_event_out));
